// *** design/cto_pkg.sv ***
package cto_pkg;

  // register byte offsets on the bus
  localparam logic [7:0] ADDR_CTRL  = 8'h00;  // go / busy
  localparam logic [7:0] ADDR_INSTR = 8'h04;  // instruction word
  localparam logic [7:0] ADDR_ARG   = 8'h08;  // address, immediate, offset
  localparam logic [7:0] ADDR_FLAGS = 8'h0C;  // flag_register
  localparam logic [7:0] ADDR_PC    = 8'h10;  // program counter
  localparam logic [7:0] ADDR_SP    = 8'h14;  // stack pointer
  localparam logic [7:0] ADDR_GSEL  = 8'h18;  // working register select
  localparam logic [7:0] ADDR_GDATA = 8'h1C;  // selected working register
  localparam logic [7:0] ADDR_CYC   = 8'h20;  // cycles of last instruction

  // bus answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // flag_register bit positions
  localparam int unsigned FLG_C = 0;
  localparam int unsigned FLG_Z = 1;
  localparam int unsigned FLG_N = 2;
  localparam int unsigned FLG_V = 3;
  localparam int unsigned FLG_S = 4;
  localparam int unsigned FLG_H = 5;
  localparam int unsigned FLG_T = 6;
  localparam int unsigned FLG_I = 7;

  // reset values
  localparam logic [7:0]  FLAGS_RST = 8'h00;
  localparam logic [15:0] PC_RST    = 16'h0000;
  localparam logic [15:0] SP_RST    = 16'h3FFF;

  // pointer pair select, Z pair register index for program reads
  localparam logic [1:0] PTR_Z     = 2'h3;
  localparam logic [4:0] LEN_NVM   = 5'h01;  // extra cycles through the nvm controller

  // operations
  typedef enum logic [5:0] {
    OP_NOP, OP_BR_OVF_SET, OP_BR_OVF_CLR, OP_BR_IRQ_EN, OP_BR_IRQ_DIS,
    OP_LOAD_DIRECT, OP_LOAD_IND, OP_LOAD_INC, OP_LOAD_DEC, OP_LOAD_OFS,
    OP_WR_ABS, OP_WR_IND, OP_WR_INC, OP_WR_DEC, OP_WR_OFS,
    OP_PMEM_RD, OP_PMEM_RD_INC, OP_IO_IN, OP_IO_OUT, OP_PUSH, OP_POP,
    OP_SHL, OP_SHR, OP_ROTL, OP_ROTR, OP_SHR_SIGN, OP_IO_SET, OP_IO_CLR,
    OP_BIT_TO_T, OP_T_TO_BIT, OP_COPY, OP_PAIR_COPY, OP_IMM, OP_NIB_SWAP
  } cto_op_t;

  // instruction word as held in its register
  typedef struct packed {
    cto_op_t    op;    // [20:15]
    logic [4:0] rd;    // [14:10] destination
    logic [4:0] rr;    // [9:5] source
    logic [2:0] bsel;  // [4:2] bit number
    logic [1:0] ptr;   // [1:0] 1 first pair, 2 second, 3 third
  } cto_instr_t;

  // memory or i/o request toward the far side
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        re;
    logic        we;
  } cto_req_t;

  typedef enum logic {EX_IDLE = 1'b0, EX_RUN = 1'b1} cto_state_t;

endpackage

// *** design/cto_core.sv ***
`timescale 1ns/100ps
module cto_core
  import cto_pkg::*;
#(
  parameter logic [15:0] NVM_BASE = 16'h4000  // data addresses at or above go through nvm
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output cto_req_t         dmem_req,
  input  wire logic [7:0]  dmem_rdata,
  input  wire logic        dmem_wait,
  output logic [15:0]      pmem_addr,
  output logic             pmem_re,
  input  wire logic [7:0]  pmem_rdata,
  output cto_req_t         io_req,
  input  wire logic [7:0]  io_rdata,
  output logic             busy,
  output logic             done
);

  cto_state_t  state_r;          // idle or executing
  cto_instr_t  instr_r;          // instruction register
  logic [15:0] arg_r;            // k / K / q / A field
  logic [7:0]  flags_r;          // flag_register
  logic [15:0] pc_r;             // program counter
  logic [15:0] sp_r;             // stack pointer
  logic [4:0]  gsel_r;           // working register select
  logic [7:0]  gpr_r [32];       // working registers
  logic [15:0] addr_r;           // latched access address
  logic [15:0] pairv_r;          // pointer value to write back
  logic [4:0]  pbase_r;          // low register of pointer pair
  logic [2:0]  cnt_r;            // cycles left
  logic        first_r;          // first run cycle
  logic        taken_r;          // branch decision
  logic        nvm_r;            // access goes through nvm
  logic [7:0]  cyc_r;            // run cycle number
  logic [7:0]  cyc_last_r;       // length of last instruction
  // bus side state
  logic        aw_got_r, w_got_r, bvalid_r, rvalid_r;
  logic [7:0]  awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  logic [1:0]  bresp_r, rresp_r;
  logic [31:0] rdata_r;

  // ---------------- register bus ----------------
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[1:0] == 2'h0) && (a <= ADDR_CYC);
  endfunction

  // read mux shared by reads and byte-merged writes
  function automatic logic [31:0] rd_mux(input logic [7:0] a);
    case (a)
      ADDR_CTRL:  rd_mux = {31'h0, state_r == EX_RUN};
      ADDR_INSTR: rd_mux = {11'h0, instr_r};
      ADDR_ARG:   rd_mux = {16'h0, arg_r};
      ADDR_FLAGS: rd_mux = {24'h0, flags_r};
      ADDR_PC:    rd_mux = {16'h0, pc_r};
      ADDR_SP:    rd_mux = {16'h0, sp_r};
      ADDR_GSEL:  rd_mux = {27'h0, gsel_r};
      ADDR_GDATA: rd_mux = {24'h0, gpr_r[gsel_r]};
      ADDR_CYC:   rd_mux = {24'h0, cyc_last_r};
      default:    rd_mux = 32'h0;
    endcase
  endfunction

  logic        wr_fire;   // write applied this cycle
  logic [31:0] wmask;     // byte enables as bit mask
  logic [31:0] wval;      // merged write value
  logic        sw_ok;     // state registers writable only while idle
  logic        start;     // go accepted

  assign s_axi_awready = !aw_got_r && !bvalid_r;
  assign s_axi_wready  = !w_got_r && !bvalid_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;
  assign wr_fire = aw_got_r && w_got_r && !bvalid_r;
  assign wmask   = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
  assign wval    = (rd_mux(awaddr_r) & ~wmask) | (wdata_r & wmask);
  assign sw_ok   = wr_fire && (state_r == EX_IDLE);
  // go is refused while an instruction runs
  assign start   = sw_ok && (awaddr_r == ADDR_CTRL) && wval[0];

  // address and data accepted in either order, held until the write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r <= 1'b0;
      w_got_r  <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r  <= 32'h0;
      wstrb_r  <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_got_r <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_got_r <= 1'b0;
      end
    end
  end

  // write response, error for unmapped offsets
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r  <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_r <= 1'b1;
      bresp_r  <= mapped(awaddr_r) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // read channel, one outstanding read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0;
      rresp_r  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_r <= 1'b1;
      rdata_r  <= rd_mux(s_axi_araddr);
      rresp_r  <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // instruction, argument and select: writable only while idle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      instr_r <= '0;
      arg_r   <= 16'h0000;
      gsel_r  <= 5'h00;
    end else if (sw_ok) begin
      if (awaddr_r == ADDR_INSTR) instr_r <= cto_instr_t'(wval[20:0]);
      if (awaddr_r == ADDR_ARG)   arg_r   <= wval[15:0];
      if (awaddr_r == ADDR_GSEL)  gsel_r  <= wval[4:0];
    end
  end

  // ---------------- decode at start ----------------
  cto_op_t     op;
  logic [4:0]  s_pbase;    // pointer pair low index
  logic [15:0] s_ptr;      // pointer value
  logic [15:0] s_addr;     // access address
  logic [15:0] s_pairv;    // pointer write-back value
  logic        s_taken;    // branch decision
  logic [2:0]  s_cyc;      // base cycle count
  logic        is_load, is_store, s_nvm;

  assign op       = instr_r.op;
  // program reads always use the third pair
  assign s_pbase  = {2'h3, (op == OP_PMEM_RD || op == OP_PMEM_RD_INC) ? PTR_Z : instr_r.ptr, 1'b0};
  assign s_ptr    = {gpr_r[s_pbase | 5'h01], gpr_r[s_pbase]};
  assign is_load  = op inside {OP_LOAD_DIRECT, OP_LOAD_IND, OP_LOAD_INC, OP_LOAD_DEC, OP_LOAD_OFS, OP_POP};
  assign is_store = op inside {OP_WR_ABS, OP_WR_IND, OP_WR_INC, OP_WR_DEC, OP_WR_OFS, OP_PUSH};

  always_comb begin
    s_addr  = s_ptr;
    s_pairv = s_ptr;
    s_taken = 1'b0;
    s_cyc   = 3'd1;
    case (op)
      OP_BR_OVF_SET: s_taken = flags_r[FLG_V];
      OP_BR_OVF_CLR: s_taken = !flags_r[FLG_V];
      OP_BR_IRQ_EN:  s_taken = flags_r[FLG_I];
      OP_BR_IRQ_DIS: s_taken = !flags_r[FLG_I];
      OP_LOAD_DIRECT: begin
        s_addr = arg_r;
        s_cyc  = 3'd3;
      end
      OP_LOAD_IND: s_cyc = 3'd2;
      // read old pointer, write back plus one
      OP_LOAD_INC: begin
        s_pairv = s_ptr + 16'h0001;
        s_cyc   = 3'd2;
      end
      OP_LOAD_DEC: begin
        s_addr  = s_ptr - 16'h0001;
        s_pairv = s_addr;
        s_cyc   = 3'd2;
      end
      OP_LOAD_OFS: begin
        s_addr = s_ptr + {10'h000, arg_r[5:0]};
        s_cyc  = 3'd2;
      end
      OP_WR_ABS: s_addr = arg_r;
      // write old pointer, then plus one
      OP_WR_INC: s_pairv = s_ptr + 16'h0001;
      OP_WR_DEC: begin
        s_addr  = s_ptr - 16'h0001;
        s_pairv = s_addr;
      end
      OP_WR_OFS: s_addr = s_ptr + {10'h000, arg_r[5:0]};
      OP_PMEM_RD: s_cyc = 3'd3;
      OP_PMEM_RD_INC: begin
        s_pairv = s_ptr + 16'h0001;
        s_cyc   = 3'd3;
      end
      // push at sp, pop from sp plus one
      OP_PUSH: s_addr = sp_r;
      OP_POP: begin
        s_addr = sp_r + 16'h0001;
        s_cyc  = 3'd2;
      end
      OP_IO_IN, OP_IO_OUT, OP_IO_SET, OP_IO_CLR: s_addr = {10'h000, arg_r[5:0]};
      default: s_addr = s_ptr;
    endcase
    if (s_taken) s_cyc = 3'd2;
  end
  // nvm-routed data access costs one more cycle
  assign s_nvm = (is_load || is_store) && (s_addr >= NVM_BASE);

  // ---------------- sequencing ----------------
  logic last;   // final cycle of the instruction
  logic run;
  assign run  = (state_r == EX_RUN);
  // controller wait stretches the final cycle
  assign last = run && (cnt_r == 3'd0) && !((is_load || is_store) && dmem_wait);
  assign busy = run;
  assign done = last;

  // state, counter and latched operands
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= EX_IDLE;
      cnt_r   <= 3'd0;
      first_r <= 1'b0;
      addr_r  <= 16'h0000;
      pairv_r <= 16'h0000;
      pbase_r <= 5'h00;
      taken_r <= 1'b0;
      nvm_r   <= 1'b0;
    end else if (start) begin
      state_r <= EX_RUN;
      cnt_r   <= 3'(s_cyc - 3'd1 + (s_nvm ? 3'(LEN_NVM) : 3'd0));
      first_r <= 1'b1;
      addr_r  <= s_addr;
      pairv_r <= s_pairv;
      pbase_r <= s_pbase;
      taken_r <= s_taken;
      nvm_r   <= s_nvm;
    end else if (run) begin
      first_r <= 1'b0;
      if (cnt_r != 3'd0) cnt_r <= cnt_r - 3'd1;
      if (last) state_r <= EX_IDLE;
    end
  end

  // cycle count of the running and the last instruction
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cyc_r      <= 8'h00;
      cyc_last_r <= 8'h00;
    end else if (start) begin
      cyc_r <= 8'h01;
    end else if (run) begin
      cyc_r <= cyc_r + 8'h01;
      if (last) cyc_last_r <= cyc_r;
    end
  end

  // ---------------- far-side requests ----------------
  logic [7:0] bmask;  // selected bit as mask
  assign bmask = 8'h01 << instr_r.bsel;

  // strobes only in the first run cycle; read data used at the last
  always_comb begin
    dmem_req.addr  = addr_r;
    dmem_req.wdata = gpr_r[instr_r.rr];
    dmem_req.re    = run && first_r && is_load;
    dmem_req.we    = run && first_r && is_store;
    pmem_addr      = addr_r;
    pmem_re        = run && first_r && (op == OP_PMEM_RD || op == OP_PMEM_RD_INC);
    io_req.addr    = addr_r;
    io_req.re      = run && (op == OP_IO_IN || op == OP_IO_SET || op == OP_IO_CLR);
    io_req.we      = run && (op == OP_IO_OUT || op == OP_IO_SET || op == OP_IO_CLR);
    io_req.wdata   = gpr_r[instr_r.rr];
    if (op == OP_IO_SET) io_req.wdata = io_rdata | bmask;
    if (op == OP_IO_CLR) io_req.wdata = io_rdata & ~bmask;
  end

  // ---------------- commit at last cycle ----------------
  logic        res_we, pair_we;
  logic [7:0]  res_val, opnd, sh;
  logic [15:0] pair_val;
  logic [4:0]  pair_idx;
  logic [7:0]  flags_nxt;
  logic [15:0] pc_nxt, sp_nxt;

  assign opnd = gpr_r[instr_r.rd];
  // single bits of the operand, sampled by the checks below
  logic sel_bit, opnd_sign;
  assign sel_bit   = opnd[instr_r.bsel];
  assign opnd_sign = opnd[7];

  always_comb begin
    res_we    = 1'b0;
    res_val   = 8'h00;
    pair_we   = 1'b0;
    pair_idx  = pbase_r;
    pair_val  = pairv_r;
    flags_nxt = flags_r;
    sp_nxt    = sp_r;
    sh        = opnd;
    pc_nxt    = pc_r + ((op == OP_LOAD_DIRECT || op == OP_WR_ABS) ? 16'h0002 : 16'h0001);
    case (op)
      OP_BR_OVF_SET, OP_BR_OVF_CLR, OP_BR_IRQ_EN, OP_BR_IRQ_DIS:
        if (taken_r) pc_nxt = pc_r + {{9{arg_r[6]}}, arg_r[6:0]} + 16'h0001;
      OP_LOAD_DIRECT, OP_LOAD_IND, OP_LOAD_OFS: begin
        res_we  = 1'b1;
        res_val = dmem_rdata;
      end
      OP_LOAD_INC, OP_LOAD_DEC: begin
        res_we  = 1'b1;
        res_val = dmem_rdata;
        pair_we = 1'b1;
      end
      OP_WR_INC, OP_WR_DEC: pair_we = 1'b1;
      OP_PMEM_RD, OP_PMEM_RD_INC: begin
        res_we  = 1'b1;
        res_val = pmem_rdata;
        pair_we = (op == OP_PMEM_RD_INC);
      end
      OP_IO_IN: begin
        res_we  = 1'b1;
        res_val = io_rdata;
      end
      OP_PUSH: sp_nxt = sp_r - 16'h0001;
      OP_POP: begin
        sp_nxt  = sp_r + 16'h0001;
        res_we  = 1'b1;
        res_val = dmem_rdata;
      end
      OP_SHL, OP_ROTL: begin
        sh = {opnd[6:0], (op == OP_ROTL) ? flags_r[FLG_C] : 1'b0};
        flags_nxt[FLG_C] = opnd[7];
        flags_nxt[FLG_H] = opnd[3];
      end
      OP_SHR, OP_ROTR, OP_SHR_SIGN: begin
        sh = {(op == OP_ROTR) ? flags_r[FLG_C] : (op == OP_SHR_SIGN) ? opnd[7] : 1'b0, opnd[7:1]};
        flags_nxt[FLG_C] = opnd[0];
      end
      OP_BIT_TO_T: flags_nxt[FLG_T] = |(opnd & bmask);
      OP_T_TO_BIT: begin
        res_we  = 1'b1;
        res_val = flags_r[FLG_T] ? (opnd | bmask) : (opnd & ~bmask);
      end
      OP_COPY: begin
        res_we  = 1'b1;
        res_val = gpr_r[instr_r.rr];
      end
      OP_PAIR_COPY: begin
        pair_we  = 1'b1;
        pair_idx = instr_r.rd & 5'h1E;
        pair_val = {gpr_r[instr_r.rr | 5'h01], gpr_r[instr_r.rr & 5'h1E]};
      end
      OP_IMM: begin
        res_we  = 1'b1;
        res_val = arg_r[7:0];
      end
      OP_NIB_SWAP: begin
        res_we  = 1'b1;
        res_val = {opnd[3:0], opnd[7:4]};
      end
      default: res_we = 1'b0;
    endcase
    // common shift flags, overflow is negative xor carry
    if (op inside {OP_SHL, OP_ROTL, OP_SHR, OP_ROTR, OP_SHR_SIGN}) begin
      res_we           = 1'b1;
      res_val          = sh;
      flags_nxt[FLG_Z] = (sh == 8'h00);
      flags_nxt[FLG_N] = sh[7];
      flags_nxt[FLG_V] = sh[7] ^ flags_nxt[FLG_C];
      flags_nxt[FLG_S] = flags_nxt[FLG_N] ^ flags_nxt[FLG_V];
    end
  end

  // flags, pc and sp: software while idle, hardware at the last cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_r <= FLAGS_RST;
      pc_r    <= PC_RST;
      sp_r    <= SP_RST;
    end else if (last) begin
      flags_r <= flags_nxt;
      pc_r    <= pc_nxt;
      sp_r    <= sp_nxt;
    end else if (sw_ok) begin
      if (awaddr_r == ADDR_FLAGS) flags_r <= wval[7:0];
      if (awaddr_r == ADDR_PC)    pc_r    <= wval[15:0];
      if (awaddr_r == ADDR_SP)    sp_r    <= wval[15:0];
    end
  end

  // working registers, pair write wins over result on overlap
  for (genvar i = 0; i < 32; i++) begin : g_gpr
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        gpr_r[i] <= 8'h00;
      end else if (sw_ok && awaddr_r == ADDR_GDATA && gsel_r == 5'(i)) begin
        gpr_r[i] <= wval[7:0];
      end else if (last && pair_we && pair_idx == 5'(i)) begin
        gpr_r[i] <= pair_val[7:0];
      end else if (last && pair_we && (pair_idx | 5'h01) == 5'(i)) begin
        gpr_r[i] <= pair_val[15:8];
      end else if (last && res_we && instr_r.rd == 5'(i)) begin
        gpr_r[i] <= res_val;
      end
    end
  end

  // ---------------- checks ----------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_go(cto_op_t o);
    start && op == o && !s_nvm;
  endsequence

  property p_ovf_taken;
    start && s_taken && (op == OP_BR_OVF_SET || op == OP_BR_OVF_CLR) |-> ##1 !done ##1 done;
  endproperty
  a_ovf_taken: assert property (p_ovf_taken) else $error("overflow branch length");

  property p_irq_flags;
    done && (op == OP_BR_IRQ_EN || op == OP_BR_IRQ_DIS) |=> flags_r == $past(flags_r);
  endproperty
  a_irq_flags: assert property (p_irq_flags) else $error("irq branch changed flags");

  property p_direct_len;
    s_go(OP_LOAD_DIRECT) |-> ##1 dmem_req.re ##1 !done ##1 done;
  endproperty
  a_direct_len: assert property (p_direct_len) else $error("direct load length");

  // pointer ends one above the address that was read
  property p_inc_load;
    s_go(OP_LOAD_INC) |-> ##2 done ##1 ({gpr_r[pbase_r | 5'h01], gpr_r[pbase_r]} == addr_r + 16'h0001);
  endproperty
  a_inc_load: assert property (p_inc_load) else $error("post-increment load timing");

  property p_abs_store;
    s_go(OP_WR_ABS) |-> ##1 (dmem_req.we && done && dmem_req.addr == $past(arg_r));
  endproperty
  a_abs_store: assert property (p_abs_store) else $error("absolute store");

  property p_pmem_len;
    start && (op == OP_PMEM_RD || op == OP_PMEM_RD_INC) |-> ##1 pmem_re ##2 done;
  endproperty
  a_pmem_len: assert property (p_pmem_len) else $error("program read length");

  property p_pop_len;
    s_go(OP_POP) |-> ##1 !done ##1 done ##1 (sp_r == $past(sp_r, 3) + 16'h0001);
  endproperty
  a_pop_len: assert property (p_pop_len) else $error("pop timing or sp");

  property p_asr_sign;
    done && op == OP_SHR_SIGN |=> gpr_r[instr_r.rd][7] == $past(opnd_sign);
  endproperty
  a_asr_sign: assert property (p_asr_sign) else $error("sign bit not kept");

  property p_nvm_extra;
    start && s_nvm |=> !done;
  endproperty
  a_nvm_extra: assert property (p_nvm_extra) else $error("nvm access too fast");

  property p_bit_to_t;
    done && op == OP_BIT_TO_T |=> flags_r[FLG_T] == $past(sel_bit);
  endproperty
  a_bit_to_t: assert property (p_bit_to_t) else $error("transfer flag wrong");

endmodule // cto_core

// *** tb/cto_mem_model.sv ***
`timescale 1ns/100ps
// data, program and i/o space behind the core
module cto_mem_model
  import cto_pkg::*;
(
  input  wire logic        aclk,
  input  wire cto_req_t    dmem_req,
  output logic [7:0]       dmem_rdata,
  output logic             dmem_wait,
  input  wire logic [15:0] pmem_addr,
  input  wire logic        pmem_re,
  output logic [7:0]       pmem_rdata,
  input  wire cto_req_t    io_req,
  output logic [7:0]       io_rdata
);
  logic [7:0] dm [256];  // data bytes, low address byte only
  logic [7:0] io [64];   // i/o locations
  initial for (int i = 0; i < 256; i++) dm[i] = 8'(i) ^ 8'hA5;
  initial for (int i = 0; i < 64; i++) io[i] = 8'(i * 3);
  assign dmem_wait = 1'h0;
  assign io_rdata = io[io_req.addr[5:0]];
  always @(posedge aclk) begin
    if (dmem_req.re) dmem_rdata <= dm[dmem_req.addr[7:0]];
    if (dmem_req.we) dm[dmem_req.addr[7:0]] <= dmem_req.wdata;
    if (pmem_re) pmem_rdata <= pmem_addr[7:0] ^ 8'h3C;
    if (io_req.we) io[io_req.addr[5:0]] <= io_req.wdata;
  end
endmodule // cto_mem_model

// *** tb/testbench.sv ***
`timescale 1ns/100ps
module testbench;
  import cto_pkg::*;
  logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, busy, done, dmem_wait, pmem_re, tk;
  logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0, dmem_rdata, pmem_rdata, io_rdata;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, q, v, k, s = 32'h8EF7;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic [15:0] pmem_addr;
  cto_req_t    dmem_req, io_req;
  int          failures = 0, check_count = 0, runs = 0, dones = 0;
  logic [7:0]  e, f;
  always #4 aclk = ~aclk;
  // busy cycles of the running instruction
  always @(posedge aclk) if (busy === 1'h1) runs <= runs + 1;
  // done pulses of the running instruction
  always @(posedge aclk) if (done === 1'h1) dones <= dones + 1;
  cto_core dut (.*);
  cto_mem_model mdl (.*);
  function automatic logic [31:0] xs();
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction
  task automatic close_out();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("wrong value at %0t got %h expected %h", $time, g, e);
    end
  endtask
  // one axi-lite write (w=1) or read, handshakes judged before each edge
  task automatic bus(input bit w, input logic [7:0] a, input logic [31:0] d);
    bit ta, tw, tb, tr, tar;
    if (w) {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'h7};
    else {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
    for (int i = 0; i < 40; i++) begin
      @(negedge aclk);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      tb = s_axi_bready & s_axi_bvalid;
      tr = s_axi_rready & s_axi_rvalid;
      tar = s_axi_arvalid & s_axi_arready;
      if (tb) r = s_axi_bresp;
      if (tr) {q, r} = {s_axi_rdata, s_axi_rresp};
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 0;
      if (tw) s_axi_wvalid <= 0;
      if (tar) s_axi_arvalid <= 0;
      if (tb) s_axi_bready <= 0;
      if (tr) s_axi_rready <= 0;
      // one idle edge so the next call never re-raises a strobe in this step
      if (tb | tr) begin
        @(posedge aclk);
        return;
      end
    end
    failures++;
    close_out();
  endtask
  // load, start, and wait for the core to go idle
  task automatic run(input cto_op_t op, input logic [4:0] rd, rr, input logic [2:0] b, p, input logic [31:0] a);
    bus(1, ADDR_INSTR, 32'(cto_instr_t'{op, rd, rr, b, p[1:0]}));
    bus(1, ADDR_ARG, a);
    runs = 0;
    dones = 0;
    bus(1, ADDR_CTRL, 32'h1);
    for (int i = 0; i < 20; i++) begin
      @(negedge aclk);
      if (busy === 1'h0) break;
    end
    if (busy !== 1'h0) begin
      failures++;
      close_out();
    end
    @(posedge aclk);
    chk(32'(dones), 1);
  endtask
  task automatic rg(input logic [4:0] i);
    bus(1, ADDR_GSEL, 32'(i));
    bus(0, ADDR_GDATA, 0);
  endtask
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1;
    bus(0, ADDR_SP, 0);
    chk(q, 32'h3FFF);
    bus(0, 8'h24, 0);
    chk({q[29:0], r}, 32'(RESP_SLVERR));
    // the four flag branches, random flags and offsets
    for (int i = 0; i < 4; i++) begin
      v = xs() & 32'hFF;
      k = xs() & 32'h7F;
      bus(1, ADDR_FLAGS, v);
      bus(1, ADDR_PC, 32'h100);
      run(cto_op_t'(int'(OP_BR_OVF_SET) + i), 0, 0, 0, 0, k);
      tk = (i < 2 ? v[FLG_V] : v[FLG_I]) ^ i[0];
      chk(32'(runs), tk ? 2 : 1);
      bus(0, ADDR_PC, 0);
      chk(q, tk ? (32'h101 + (k[6] ? k | 32'hFFFFFF80 : k)) & 32'hFFFF : 32'h101);
      bus(0, ADDR_FLAGS, 0);
      chk(q, v);
    end
    $display("branch test done");
    v = xs() & 32'hFF;
    bus(1, ADDR_GSEL, 26);
    bus(1, ADDR_GDATA, v);
    run(OP_LOAD_INC, 5, 0, 0, 1, 0);
    chk(32'(runs), 2);
    rg(5);
    chk(q, v ^ 32'hA5);
    rg(26);
    chk(q, (v + 1) & 32'hFF);
    run(OP_WR_ABS, 0, 5, 0, 0, 32'h40);
    chk(32'(runs), 1);
    chk(32'(mdl.dm[64]), v ^ 32'hA5);
    run(OP_LOAD_DIRECT, 6, 0, 0, 0, 32'h4010);
    chk(32'(runs), 4);
    bus(0, ADDR_CYC, 0);
    chk(q, 32'h4);
    rg(6);
    chk(q, 32'hB5);
    k = xs() & 32'h7;
    run(OP_IO_SET, 0, 0, k[2:0], 0, 32'h3);
    chk(32'(mdl.io[3]), 32'h9 | (32'h1 << k));
    $display("transfer test done");
    // shifts on random data and flags, results worked out from the rules
    for (int i = 0; i < 5; i++) begin
      v = xs() & 32'hFF;
      k = xs() & 32'hFF;
      bus(1, ADDR_FLAGS, k);
      bus(1, ADDR_GSEL, 7);
      bus(1, ADDR_GDATA, v);
      run(cto_op_t'(int'(OP_SHL) + i), 7, 0, 0, 0, 0);
      chk(32'(runs), 1);
      tk = (i == 0 || i == 2) ? v[7] : v[0];
      e = i == 0 ? {v[6:0], 1'b0} : i == 2 ? {v[6:0], k[0]} : {i == 3 ? k[0] : i == 4 ? v[7] : 1'b0, v[7:1]};
      f = k[7:0];
      f[FLG_C] = tk;
      f[FLG_Z] = e == 8'h00;
      f[FLG_N] = e[7];
      f[FLG_V] = e[7] ^ tk;
      f[FLG_S] = tk;
      if (i == 0 || i == 2) f[FLG_H] = v[3];
      rg(7);
      chk(q, 32'(e));
      bus(0, ADDR_FLAGS, 0);
      chk(q, 32'(f));
    end
    k = xs() & 32'h7;
    run(OP_BIT_TO_T, 7, 0, k[2:0], 0, 0);
    bus(0, ADDR_FLAGS, 0);
    chk(32'(q[FLG_T]), 32'(e[k[2:0]]));
    run(OP_T_TO_BIT, 8, 0, k[2:0], 0, 0);
    rg(8);
    chk(q, e[k[2:0]] ? 32'h1 << k : 32'h0);
    run(OP_PUSH, 0, 7, 0, 0, 0);
    chk(32'(mdl.dm[255]), 32'(e));
    run(OP_POP, 9, 0, 0, 0, 0);
    chk(32'(runs), 2);
    rg(9);
    chk(q, 32'(e));
    bus(0, ADDR_SP, 0);
    chk(q, 32'h3FFF);
    run(OP_PMEM_RD_INC, 10, 0, 0, 0, 0);
    chk(32'(runs), 3);
    rg(10);
    chk(q, 32'h3C);
    rg(30);
    chk(q, 32'h1);
    bus(1, ADDR_GSEL, 28);
    bus(1, ADDR_GDATA, 32'h20);
    run(OP_LOAD_DEC, 11, 0, 0, 2, 0);
    chk(32'(runs), 2);
    rg(11);
    chk(q, 32'hBA);
    k = xs() & 32'h1F;
    run(OP_LOAD_OFS, 12, 0, 0, 2, k);
    chk(32'(runs), 2);
    rg(12);
    chk(q, (32'h1F + k) ^ 32'hA5);
    rg(28);
    chk(q, 32'h1F);
    run(OP_IO_IN, 13, 0, 0, 0, 5);
    rg(13);
    chk(q, 32'hF);
    run(OP_IO_OUT, 0, 13, 0, 0, 6);
    chk(32'(mdl.io[6]), 32'hF);
    run(OP_IO_CLR, 0, 0, 0, 0, 5);
    chk(32'(mdl.io[5]), 32'hE);
    v = xs() & 32'hFF;
    run(OP_IMM, 14, 0, 0, 0, v);
    run(OP_NIB_SWAP, 14, 0, 0, 0, 0);
    run(OP_COPY, 15, 14, 0, 0, 0);
    chk(32'(runs), 1);
    rg(15);
    chk(q, 32'({v[3:0], v[7:4]}));
    run(OP_WR_DEC, 0, 15, 0, 2, 0);
    chk(32'(mdl.dm[30]), 32'({v[3:0], v[7:4]}));
    rg(28);
    chk(q, 32'h1E);
    $display("bit and stack test done");
    close_out();
  end
endmodule // testbench
